// ### logic/hbc_cmd_regs.sv
// Identification and command registers of the bridge function with error messaging
// Functional notes
// - Fixed identification code, writes ignored
// - Command register at offset four, reset 0006h
// - Fast back-to-back enable fixed zero
// - Bit 8 writable system error message enable
// - Errors signalled only by hub message
// - Message mechanism enabled by either function
// - Stepping bit fixed zero
// - Parity response enable fixed zero
// - Palette snoop fixed zero
// - Write-and-invalidate enable fixed zero
// - Special cycle enable zero, cycles ignored
// - Bus master permit reads one
// - Memory access permit reads one
// - I/O access permit fixed zero
// - Sent message sets status bit fourteen
`timescale 1ns/1ps
`default_nettype none
`include "hbc_consts.svh"
module hbc_cmd_regs
  import hbc_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          cfg_rd,
  input  wire logic          cfg_wr,
  input  wire hbc_pkg::hbc_addr_t cfg_addr,
  input  wire logic [1:0]    cfg_be,
  input  wire hbc_pkg::hbc_word_t cfg_wdata,
  output var  hbc_pkg::hbc_word_t cfg_rdata,
  output var  logic          cfg_rvalid,
  input  wire logic          func1_serr_enable,
  input  wire logic          error_event,
  output var  logic          serr_msg_req,
  input  wire logic          serr_msg_ack,
  output var  logic          system_error_message_enable,
  output var  logic          msg_mechanism_enable,
  output var  logic          bus_master_permit,
  output var  logic          memory_access_permit,
  output var  logic          io_access_permit,
  output var  logic          special_cycle_accept
);
  import hbc_pkg::*;

  // ==========================================================================
  // Address decode
  logic hit_devid;
  logic hit_cmd;
  logic hit_sts;
  logic cmd_wr_hi;
  logic sts_clear;

  assign hit_devid = (cfg_addr == `HBC_OFF_DEVID);
  assign hit_cmd   = (cfg_addr == `HBC_OFF_CMD);
  assign hit_sts   = (cfg_addr == `HBC_OFF_STATUS);
  // Only the upper byte holds a writable bit, so only its lane matters
  assign cmd_wr_hi = cfg_wr & hit_cmd & cfg_be[1];
  assign sts_clear = cfg_wr & hit_sts & cfg_be[1] & cfg_wdata[`HBC_STS_SSE_BIT];

  // ==========================================================================
  // Command register: one stored bit, the rest constant
  logic system_error_message_enable_q;
  logic system_error_message_enable_d;
  localparam hbc_word_t cmd_reset_val = `HBC_CMD_RESET;

  assign system_error_message_enable_d = cmd_wr_hi ? cfg_wdata[`HBC_CMD_SYSTEM_ERROR_MESSAGE_ENABLE_BIT] : system_error_message_enable_q;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      system_error_message_enable_q <= cmd_reset_val[`HBC_CMD_SYSTEM_ERROR_MESSAGE_ENABLE_BIT];
    else
      system_error_message_enable_q <= system_error_message_enable_d;
  end

  // ==========================================================================
  // Named command fields; all but the enable come from the fixed pattern
  localparam hbc_word_t cmd_fixed_val = `HBC_CMD_FIXED;
  logic cmd_fast_b2b;
  logic cmd_stepping;
  logic cmd_parity_resp;
  logic cmd_palette_snoop;
  logic cmd_write_inval;
  logic cmd_special_cycle;
  logic cmd_bus_master;
  logic cmd_memory_access;
  logic cmd_io_access;

  assign cmd_fast_b2b      = cmd_fixed_val[`HBC_CMD_FB2B_BIT];
  assign cmd_stepping      = cmd_fixed_val[`HBC_CMD_STEP_BIT];
  assign cmd_parity_resp   = cmd_fixed_val[`HBC_CMD_PARITY_ERROR_RESPONSE_ENABLE_BIT];
  assign cmd_palette_snoop = cmd_fixed_val[`HBC_CMD_PAL_BIT];
  assign cmd_write_inval   = cmd_fixed_val[`HBC_CMD_MWI_BIT];
  assign cmd_special_cycle = cmd_fixed_val[`HBC_CMD_SPC_BIT];
  assign cmd_bus_master    = cmd_fixed_val[`HBC_CMD_BME_BIT];
  assign cmd_memory_access = cmd_fixed_val[`HBC_CMD_MAE_BIT];
  assign cmd_io_access     = cmd_fixed_val[`HBC_CMD_IO_ACCESS_PERMIT_BIT];

  // Read value; nothing lands above the fast back-to-back bit, so the reserved top reads zero
  hbc_word_t cmd_value;
  assign cmd_value = ({15'h0000, cmd_fast_b2b}      << `HBC_CMD_FB2B_BIT)
                   | ({15'h0000, system_error_message_enable_q}           << `HBC_CMD_SYSTEM_ERROR_MESSAGE_ENABLE_BIT)
                   | ({15'h0000, cmd_stepping}      << `HBC_CMD_STEP_BIT)
                   | ({15'h0000, cmd_parity_resp}   << `HBC_CMD_PARITY_ERROR_RESPONSE_ENABLE_BIT)
                   | ({15'h0000, cmd_palette_snoop} << `HBC_CMD_PAL_BIT)
                   | ({15'h0000, cmd_write_inval}   << `HBC_CMD_MWI_BIT)
                   | ({15'h0000, cmd_special_cycle} << `HBC_CMD_SPC_BIT)
                   | ({15'h0000, cmd_bus_master}    << `HBC_CMD_BME_BIT)
                   | ({15'h0000, cmd_memory_access} << `HBC_CMD_MAE_BIT)
                   | ({15'h0000, cmd_io_access}     << `HBC_CMD_IO_ACCESS_PERMIT_BIT);

  // ==========================================================================
  // Error message sender; there is no error pin, only a hub message
  hbc_msg_state_t state_q;
  hbc_msg_state_t state_d;
  logic           mech_en;
  logic           fire;
  logic           msg_done;

  assign mech_en  = system_error_message_enable_q | func1_serr_enable;
  // Only function-0 events gated by its own enable start a message
  assign fire     = (state_q == HBC_MSG_IDLE) & error_event & system_error_message_enable_q;
  assign msg_done = (state_q == HBC_MSG_SEND) & serr_msg_ack;

  always_comb
  begin
    case (state_q)
      HBC_MSG_IDLE: state_d = fire ? HBC_MSG_SEND : HBC_MSG_IDLE;
      HBC_MSG_SEND: state_d = serr_msg_ack ? HBC_MSG_IDLE : HBC_MSG_SEND;
      default:      state_d = HBC_MSG_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      state_q <= HBC_MSG_IDLE;
    else
      state_q <= state_d;
  end

  // ==========================================================================
  // Signaled system error flag, set when the hub acknowledges the message
  logic sse_flag;

  hbc_sticky_flag u_sse_flag (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .set_pulse   (msg_done),
    .clear_pulse (sts_clear),
    .flag        (sse_flag)
  );

  hbc_word_t sts_value;
  assign sts_value = `HBC_STS_FIXED | ({15'h0000, sse_flag} << `HBC_STS_SSE_BIT);

  // ==========================================================================
  // Read data mux; unmapped offsets read zero, writes elsewhere are dropped
  hbc_word_t rdata_d;
  assign rdata_d = hit_devid ? `HBC_DEVID_VALUE :
                   hit_cmd   ? cmd_value :
                   hit_sts   ? sts_value : 16'h0000;

  // Registered outputs
  hbc_word_t rdata_q;
  logic      rvalid_q;
  logic      req_q;
  logic      system_error_message_enable_o_q;
  logic      mech_q;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      rdata_q   <= 16'h0000;
      rvalid_q  <= 1'b0;
      req_q     <= 1'b0;
      system_error_message_enable_o_q <= 1'b0;
      mech_q    <= 1'b0;
    end
    else
    begin
      rdata_q   <= cfg_rd ? rdata_d : 16'h0000;
      rvalid_q  <= cfg_rd;
      req_q     <= (state_d == HBC_MSG_SEND);
      system_error_message_enable_o_q <= system_error_message_enable_q;
      mech_q    <= mech_en;
    end
  end

  // Constant permits, still from flip-flops to keep outputs registered
  logic bme_q;
  logic mae_q;
  logic io_q;
  logic spc_q;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      bme_q <= 1'b0;
      mae_q <= 1'b0;
      io_q  <= 1'b0;
      spc_q <= 1'b0;
    end
    else
    begin
      bme_q <= cmd_bus_master;
      mae_q <= cmd_memory_access;
      io_q  <= cmd_io_access;
      spc_q <= cmd_special_cycle;
    end
  end

  assign cfg_rdata                   = rdata_q;
  assign cfg_rvalid                  = rvalid_q;
  assign serr_msg_req                = req_q;
  assign system_error_message_enable = system_error_message_enable_o_q;
  assign msg_mechanism_enable        = mech_q;
  assign bus_master_permit           = bme_q;
  assign memory_access_permit        = mae_q;
  assign io_access_permit            = io_q;
  assign special_cycle_accept        = spc_q;
endmodule : hbc_cmd_regs
`default_nettype wire

// ### logic/hbc_consts.svh
// Constants for the hub bridge command and identification registers
`ifndef HBC_CONSTS_SVH
`define HBC_CONSTS_SVH

// ==========================================================================
// Configuration offsets (byte addresses within function 0 space)
`define HBC_ADDR_W          8
`define HBC_OFF_DEVID       8'h02
`define HBC_OFF_CMD         8'h04
`define HBC_OFF_STATUS      8'h06

// ==========================================================================
// Command register layout
`define HBC_CMD_RESET       16'h0006
`define HBC_CMD_WMASK       16'h0100
`define HBC_CMD_FIXED       16'h0006
`define HBC_CMD_SYSTEM_ERROR_MESSAGE_ENABLE_BIT   8
`define HBC_CMD_FB2B_BIT    9
`define HBC_CMD_STEP_BIT    7
`define HBC_CMD_PARITY_ERROR_RESPONSE_ENABLE_BIT   6
`define HBC_CMD_PAL_BIT     5
`define HBC_CMD_MWI_BIT     4
`define HBC_CMD_SPC_BIT     3
`define HBC_CMD_BME_BIT     2
`define HBC_CMD_MAE_BIT     1
`define HBC_CMD_IO_ACCESS_PERMIT_BIT    0

// ==========================================================================
// Status register layout (the signaled system error flag is the only live bit, the rest read fixed)
`define HBC_STS_SSE_BIT     14
`define HBC_STS_FIXED       16'h0090

// Arbitrary identification value, not tied to any real part
`define HBC_DEVID_VALUE     16'h5a3c

`endif

// ### logic/hbc_pkg.sv
// Types shared by the hub bridge command register block
`default_nettype none
package hbc_pkg;
  typedef logic [15:0] hbc_word_t;
  typedef logic [7:0]  hbc_addr_t;
  // Message sender states, one-hot
  typedef enum logic [1:0] {
    HBC_MSG_IDLE = 2'b01,
    HBC_MSG_SEND = 2'b10
  } hbc_msg_state_t;
endpackage : hbc_pkg
`default_nettype wire

// ### logic/hbc_sticky_flag.sv
// Sticky event flag, cleared by writing one, set wins over clear
`timescale 1ns/1ps
`default_nettype none
module hbc_sticky_flag
  import hbc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic set_pulse,
  input  wire logic clear_pulse,
  output var  logic flag
);
  // ==========================================================================
  // Flag storage
  logic flag_q;
  logic flag_d;

  // Hardware set dominates so an event in the clearing cycle is kept
  assign flag_d = set_pulse | (flag_q & ~clear_pulse);
  assign flag   = flag_q;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      flag_q <= 1'b0;
    else
      flag_q <= flag_d;
  end
endmodule : hbc_sticky_flag
`default_nettype wire

// ### tb/hbc_hub_model.sv
// Behavioural I/O hub that takes error messages from the bridge
`timescale 1ns/1ps
`default_nettype none
module hbc_hub_model
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic serr_msg_req,
  input  wire logic slow,
  output var  logic serr_msg_ack
);
  logic [2:0] wait_q;
  // =====================================================================
  // Accept
  // One ack pulse per message; the slow mode stalls to stretch the request
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !serr_msg_req || serr_msg_ack)
    begin
      wait_q       <= 3'h0;
      serr_msg_ack <= 1'b0;
    end
    else
    begin
      wait_q       <= wait_q + 3'h1;
      serr_msg_ack <= (wait_q == (slow ? 3'h5 : 3'h0));
    end
  end
endmodule : hbc_hub_model
`default_nettype wire

// ### tb/hbc_cmd_regs_checker.sv
// Port assertions for the bridge command registers
`timescale 1ns/1ps
`default_nettype none
`include "hbc_consts.svh"
module hbc_cmd_regs_checker
  import hbc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire hbc_pkg::hbc_addr_t cfg_addr,
  input wire logic [1:0] cfg_be,
  input wire hbc_pkg::hbc_word_t cfg_wdata,
  input wire hbc_pkg::hbc_word_t cfg_rdata,
  input wire logic cfg_rvalid,
  input wire logic func1_serr_enable,
  input wire logic error_event,
  input wire logic serr_msg_req,
  input wire logic serr_msg_ack,
  input wire logic system_error_message_enable,
  input wire logic msg_mechanism_enable,
  input wire logic bus_master_permit,
  input wire logic memory_access_permit,
  input wire logic io_access_permit,
  input wire logic special_cycle_accept
);
  // =====================================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  id_fixed_a: assert property (cfg_rd && cfg_addr == 8'h02 |=> cfg_rdata == `HBC_DEVID_VALUE)
    else $error("id read wrong");
  cmd_fixed_a: assert property (cfg_rd && cfg_addr == 8'h04 |=> (cfg_rdata & 16'hfeff) == 16'h0006)
    else $error("fixed command bits wrong");
  enable_wr_a: assert property (cfg_wr && cfg_addr == 8'h04 && cfg_be[1] ##2 cfg_rd && cfg_addr == 8'h04
    |=> cfg_rdata[8] == $past(cfg_wdata[8], 3)) else $error("enable bit not written");
  permits_a: assert property ($past(rst_n) |-> bus_master_permit && memory_access_permit
    && !io_access_permit && !special_cycle_accept) else $error("permit outputs wrong");
  mech_or_a: assert property ((func1_serr_enable && $past(rst_n)) [*2] |-> msg_mechanism_enable)
    else $error("mechanism enable missing");
  req_start_a: assert property ($past(error_event) && !$past(serr_msg_req) && system_error_message_enable
    |-> serr_msg_req) else $error("message not raised");
  rd_answer_a: assert property (cfg_rd |=> cfg_rvalid)
    else $error("read answer missing");
  bus_quiet_a: assert property (!cfg_rd |=> !cfg_rvalid && cfg_rdata == 16'h0000)
    else $error("read answer without read");
  req_hold_a: assert property (serr_msg_req && !serr_msg_ack |=> serr_msg_req)
    else $error("message dropped early");
  req_end_a: assert property (serr_msg_req && serr_msg_ack |=> !serr_msg_req)
    else $error("message kept after ack");
endmodule : hbc_cmd_regs_checker
bind hbc_cmd_regs hbc_cmd_regs_checker chk (.*);
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the bridge command and identification registers
`timescale 1ns/1ps
`default_nettype none
`include "hbc_consts.svh"
module tb_top;
  import hbc_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0, cfg_rd = 1'b0, cfg_wr = 1'b0, slow = 1'b0, cfg_rvalid, serr_msg_req;
  logic func1_serr_enable = 1'b0, error_event = 1'b0, serr_msg_ack, system_error_message_enable;
  logic msg_mechanism_enable, bus_master_permit, memory_access_permit, io_access_permit, special_cycle_accept;
  logic [1:0] cfg_be = 2'h0;
  hbc_addr_t  cfg_addr = 8'h00;
  hbc_word_t  cfg_wdata = 16'h0000, cfg_rdata, rnd = 16'h0018, cmd_exp = 16'h0006, dat = 16'h0000;
  int         num_errors = 0, checks = 0, cycles = 0;
  hbc_cmd_regs DUT (.*);
  hbc_hub_model hub (.*);
  // =====================================================================
  // Clock, timeout and helpers
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles > 5000)
    begin
      num_errors++;
      give_verdict();
    end
  end
  function automatic hbc_word_t lfsr(hbc_word_t s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic check(string what, hbc_word_t seen, hbc_word_t exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(hbc_addr_t a, logic [1:0] be, hbc_word_t d);
    @(posedge core_clk);
    {cfg_wr, cfg_addr, cfg_be, cfg_wdata} <= {1'b1, a, be, d};
    @(posedge core_clk);
    cfg_wr <= 1'b0;
    if (a == 8'h04 && be[1])
      cmd_exp = 16'h0006 | (d & 16'h0100); // Only the upper lane reaches the enable
  endtask : wr
  task automatic rd(hbc_addr_t a, hbc_word_t exp, string what);
    @(posedge core_clk);
    {cfg_rd, cfg_addr} <= {1'b1, a};
    @(posedge core_clk);
    cfg_rd <= 1'b0;
    #1;
    check(what, cfg_rdata, exp);
    check("rvalid", {15'h0, cfg_rvalid}, 16'h0001);
  endtask : rd
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // =====================================================================
  // Main sequence
  initial
  begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(8'h04, 16'h0006, "cmd reset");
    for (int i = 0; i < 14; i++)
    begin
      rnd = lfsr(rnd);
      dat = (i < 2) ? {16{i[0]}} : rnd;
      wr(8'h04, dat[5:4] | {i[0], 1'b0}, dat);
      rd(8'h04, cmd_exp, "cmd");
      wr(8'h02, 2'h3, ~dat);
      rd(8'h02, `HBC_DEVID_VALUE, "id");
    end
    rd(8'h40, 16'h0000, "unmapped");
    $display("test registers done");
    wr(8'h04, 2'h3, 16'hffff);
    wr(8'h04, 2'h1, 16'h0000);
    rd(8'h04, cmd_exp, "low lane");
    func1_serr_enable <= 1'b1;
    @(posedge core_clk);
    error_event <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    check("mech", {15'h0, msg_mechanism_enable}, 16'h0001);
    check("enable on", {15'h0, system_error_message_enable}, 16'h0001);
    check("permits", {12'h0, bus_master_permit, memory_access_permit, io_access_permit, special_cycle_accept},
          16'h000c);
    wr(8'h04, 2'h2, 16'h0000);
    repeat (3) @(posedge core_clk);
    #1;
    check("quiet", {15'h0, serr_msg_req}, 16'h0000);
    check("enable off", {15'h0, system_error_message_enable}, 16'h0000);
    check("mech func1", {15'h0, msg_mechanism_enable}, 16'h0001);
    error_event <= 1'b0;
    @(posedge core_clk);
    func1_serr_enable <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    check("mech none", {15'h0, msg_mechanism_enable}, 16'h0000);
    $display("test enables done");
    for (int s = 0; s < 2; s++)
    begin
      wr(8'h04, 2'h2, 16'h0100);
      slow <= s[0];
      error_event <= 1'b1;
      @(posedge core_clk);
      error_event <= 1'b0;
      #1;
      check("req up", {15'h0, serr_msg_req}, 16'h0001);
      for (int k = 0; k < 20 && serr_msg_req !== 1'b0; k++)
      begin
        @(posedge core_clk);
        #1;
      end
      check("req done", {15'h0, serr_msg_req}, 16'h0000);
      rd(8'h06, 16'h4090, "status set");
      wr(8'h06, 2'h3, 16'h4000);
      rd(8'h06, 16'h0090, "status clear");
    end
    $display("test messages done");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
